/* src/ckd_device.sv */
// device end: key detection, direct config command interpreter, key locks
`timescale 1ns/1ps
// Function
// R1 - eeprom read at power-up feeds configuration
// R2 - patch bytes follow resource data, loaded
// R3 - full 32-byte vendor key enters config
// R4 - host uses vendor key with one part
// R5 - config mode accepts hostload or direct programming
// R6 - host writes key to address port
// R7 - 06h plus byte stores card select
// R8 - 15h plus byte selects logical device
// R9 - 47h/48h/42h set io bases, high first
// R10 - 22h/27h set interrupt selects
// R11 - 2ah/25h set dma selects
// R12 - 33h 01h activates, 00h deactivates
// R13 - host repeats setup per wanted device
// R14 - 79h activates whole chip
// R15 - 55h at control base+5 locks standard key
// R16 - 56h at control base+5 locks vendor key
// R17 - locked key sequences are ignored
// R18 - key locks also settable from eeprom
// R19 - locks cleared only by bus reset
// R20 - unactivated devices never decode
// R21 - inactive after reset, watch address port
// R22 - eeprom valid only with 55h bbh
// R23 - mismatch restarts, byte may start key
// R24 - track parameter bytes, apply to selected
module ckd_device #(
   parameter int NLD = ckd_pkg::NUM_LDEV
) (
   input wire logic clk,
   input wire logic rst_b,
   ckd_if.dev bus,
   input wire logic rom_valid,
   input wire logic [7:0] rom_sig0,
   input wire logic [7:0] rom_sig1,
   input wire logic rom_lock_std,
   input wire logic rom_lock_vnd,
   output logic config_mode,
   output logic chip_active,
   output logic [7:0] card_select,
   output logic [NLD-1:0] ldev_active,
   output logic [NLD*16-1:0] io_base0,
   output logic [NLD*16-1:0] io_base1,
   output logic [NLD*16-1:0] io_base2,
   output logic [NLD*8-1:0] irq_sel0,
   output logic [NLD*8-1:0] irq_sel1,
   output logic [NLD*8-1:0] dma_sel0,
   output logic [NLD*8-1:0] dma_sel1,
   output logic std_key_locked,
   output logic vnd_key_locked,
   output logic rom_present
);
   typedef enum logic [2:0] {CKD_IDLE, CKD_ONE, CKD_HIGH, CKD_LOW} ckd_ps_t;
   typedef struct packed {
      logic cfg;
      logic chip;
      logic [7:0] csn;
      logic [2:0] ldn;
      ckd_ps_t ps;
      logic [7:0] cmd;
      logic [7:0] hi;
      logic [NLD-1:0] act;
      logic [NLD*16-1:0] b0;
      logic [NLD*16-1:0] b1;
      logic [NLD*16-1:0] b2;
      logic [NLD*8-1:0] i0;
      logic [NLD*8-1:0] i1;
      logic [NLD*8-1:0] d0;
      logic [NLD*8-1:0] d1;
      logic lstd;
      logic lvnd;
      logic rom;
      logic rom_seen;
      logic [NLD-1:0] ldact;
   } ckd_dev_t;
   ckd_dev_t st, next_st;
   logic port_wr, key_hit, ctrl_wr;
   logic [15:0] ctrl_base;
   // -------------------------------------------------
   // key detection
   // -------------------------------------------------
   assign port_wr = bus.wr && (bus.addr == ckd_pkg::ADDR_PORT); // [R21]
   // a locked key never advances, so later sequences are ignored
   // partial key progress must not survive a bus reset
   ckd_key_match u_key (
      .clk(clk),
      .rst_b(rst_b),
      .clear(st.lvnd || st.cfg || bus.bus_reset_drive),
      .strobe(port_wr && !st.lvnd), // [R17]
      .data(bus.data),
      .hit(key_hit)
   );
   assign ctrl_base = st.b0[ckd_pkg::CTRL_LDEV*16 +: 16];
   // lock port decodes only while the control device is live
   assign ctrl_wr = bus.wr && st.act[ckd_pkg::CTRL_LDEV] && st.chip // [R15] [R16]
      && (bus.addr == ctrl_base + ckd_pkg::LOCK_OFFSET);
   // -------------------------------------------------
   // command interpreter
   // -------------------------------------------------
   always_comb begin
      next_st = st;
      // eeprom straps taken once after release, only if signature matches
      // patch bytes after the resource data are loaded outside, straps only here [R2]
      if (!st.rom_seen && rom_valid) begin // [R1]
         next_st.rom_seen = 1'b1;
         next_st.rom = (rom_sig0 == ckd_pkg::ROM_SIG0) && (rom_sig1 == ckd_pkg::ROM_SIG1); // [R22]
         if ((rom_sig0 == ckd_pkg::ROM_SIG0) && (rom_sig1 == ckd_pkg::ROM_SIG1)) begin
            next_st.lstd = st.lstd | rom_lock_std; // [R18]
            next_st.lvnd = st.lvnd | rom_lock_vnd; // [R18]
         end
      end
      if (key_hit) begin
         next_st.cfg = 1'b1; // [R3] [R5]
         next_st.ps = CKD_IDLE;
      end
      if (st.cfg && port_wr) begin
         case (st.ps)
            CKD_IDLE: begin
               // unknown bytes leave the interpreter idle
               next_st.cmd = bus.data;
               if (bus.data == ckd_pkg::CMD_CHIP_ON) begin
                  next_st.chip = 1'b1; // [R14]
                  next_st.cfg = 1'b0;
               end else if (bus.data == ckd_pkg::CMD_IO0 || bus.data == ckd_pkg::CMD_IO1
                  || bus.data == ckd_pkg::CMD_IO2) begin
                  next_st.ps = CKD_HIGH; // [R24]
               end else if (bus.data == ckd_pkg::CMD_CSN || bus.data == ckd_pkg::CMD_LDN
                  || bus.data == ckd_pkg::CMD_IRQ0 || bus.data == ckd_pkg::CMD_IRQ1
                  || bus.data == ckd_pkg::CMD_DMA0 || bus.data == ckd_pkg::CMD_DMA1
                  || bus.data == ckd_pkg::CMD_ACT) begin
                  next_st.ps = CKD_ONE; // [R24]
               end
            end
            CKD_HIGH: begin
               next_st.hi = bus.data; // [R9]
               next_st.ps = CKD_LOW;
            end
            CKD_LOW: begin
               next_st.ps = CKD_IDLE;
               // out-of-range device numbers are swallowed so no field wraps
               if (st.ldn < 3'(NLD)) begin
                  case (st.cmd)
                     ckd_pkg::CMD_IO0: next_st.b0[st.ldn*16 +: 16] = {st.hi, bus.data}; // [R9]
                     ckd_pkg::CMD_IO1: next_st.b1[st.ldn*16 +: 16] = {st.hi, bus.data}; // [R9]
                     default: next_st.b2[st.ldn*16 +: 16] = {st.hi, bus.data}; // [R9]
                  endcase
               end
            end
            default: begin
               next_st.ps = CKD_IDLE;
               if (st.cmd == ckd_pkg::CMD_CSN) begin
                  next_st.csn = bus.data; // [R7]
               end else if (st.cmd == ckd_pkg::CMD_LDN) begin
                  next_st.ldn = bus.data[2:0]; // [R8]
               end else if (st.ldn < 3'(NLD)) begin
                  case (st.cmd)
                     ckd_pkg::CMD_IRQ0: next_st.i0[st.ldn*8 +: 8] = bus.data; // [R10]
                     ckd_pkg::CMD_IRQ1: next_st.i1[st.ldn*8 +: 8] = bus.data; // [R10]
                     ckd_pkg::CMD_DMA0: next_st.d0[st.ldn*8 +: 8] = bus.data; // [R11]
                     ckd_pkg::CMD_DMA1: next_st.d1[st.ldn*8 +: 8] = bus.data; // [R11]
                     default: next_st.act[st.ldn] = bus.data[0]; // [R12] [R24]
                  endcase
               end
            end
         endcase
      end
      // -------------------------------------------------
      // key locks: set only, cleared by bus reset or rst_b alone
      // -------------------------------------------------
      if (ctrl_wr && bus.data == ckd_pkg::LOCK_STD_KEY) begin
         next_st.lstd = 1'b1; // [R15]
      end
      if (ctrl_wr && bus.data == ckd_pkg::LOCK_VND_KEY) begin
         next_st.lvnd = 1'b1; // [R16]
      end
      // -------------------------------------------------
      // output image
      // -------------------------------------------------
      // registered copy so the activation outputs come from a flop
      next_st.ldact = next_st.chip ? next_st.act : '0; // [R20]
   end
   always_ff @(posedge clk) begin
      // bus reset drive has power-on reach; nothing else clears a key lock
      if (!rst_b || bus.bus_reset_drive) begin
         st <= '0; // [R19] [R21]
         st.ps <= CKD_IDLE;
      end else begin
         st <= next_st;
      end
   end
   // -------------------------------------------------
   // outputs
   // -------------------------------------------------
   assign config_mode = st.cfg;
   assign chip_active = st.chip;
   assign card_select = st.csn;
   assign ldev_active = st.ldact; // [R20]
   assign io_base0 = st.b0;
   assign io_base1 = st.b1;
   assign io_base2 = st.b2;
   assign irq_sel0 = st.i0;
   assign irq_sel1 = st.i1;
   assign dma_sel0 = st.d0;
   assign dma_sel1 = st.d1;
   assign std_key_locked = st.lstd;
   assign vnd_key_locked = st.lvnd;
   assign rom_present = st.rom;
endmodule

/* src/ckd_pkg.sv */
// package: constants shared by both ends of the config-key link
package ckd_pkg;
   localparam int KEY_LEN = 32;
   localparam logic [7:0] KEY_BYTES [0:31] = '{
      8'h96, 8'h35, 8'h9a, 8'hcd, 8'he6, 8'hf3, 8'h79, 8'hbc,
      8'h5e, 8'haf, 8'h57, 8'h2b, 8'h15, 8'h8a, 8'hc5, 8'he2,
      8'hf1, 8'hf8, 8'h7c, 8'h3e, 8'h9f, 8'h4f, 8'h27, 8'h13,
      8'h09, 8'h84, 8'h42, 8'ha1, 8'hd0, 8'h68, 8'h34, 8'h1a};
   localparam logic [15:0] ADDR_PORT = 16'h0279;
   localparam logic [7:0] CMD_CSN = 8'h06;
   localparam logic [7:0] CMD_LDN = 8'h15;
   localparam logic [7:0] CMD_IO0 = 8'h47;
   localparam logic [7:0] CMD_IO1 = 8'h48;
   localparam logic [7:0] CMD_IO2 = 8'h42;
   localparam logic [7:0] CMD_IRQ0 = 8'h22;
   localparam logic [7:0] CMD_IRQ1 = 8'h27;
   localparam logic [7:0] CMD_DMA0 = 8'h2a;
   localparam logic [7:0] CMD_DMA1 = 8'h25;
   localparam logic [7:0] CMD_ACT = 8'h33;
   localparam logic [7:0] CMD_CHIP_ON = 8'h79;
   localparam logic [7:0] LOCK_STD_KEY = 8'h55;
   localparam logic [7:0] LOCK_VND_KEY = 8'h56;
   localparam logic [15:0] LOCK_OFFSET = 16'h0005;
   localparam logic [7:0] ROM_SIG0 = 8'h55;
   localparam logic [7:0] ROM_SIG1 = 8'hbb;
   localparam int NUM_LDEV = 6;
   localparam logic [2:0] CTRL_LDEV = 3'h2;
   localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

/* src/ckd_if.sv */
// interface: isa-style host write path between host and device
`timescale 1ns/1ps
interface ckd_if;
   logic wr;
   logic [15:0] addr;
   logic [7:0] data;
   logic bus_reset_drive;
   modport dev (input wr, input addr, input data, input bus_reset_drive);
   modport host (output wr, output addr, output data, output bus_reset_drive);
endinterface

/* src/ckd_key_match.sv */
// key matcher: walks the 32-byte vendor key over address-port writes
`timescale 1ns/1ps
module ckd_key_match (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clear,
   input wire logic strobe,
   input wire logic [7:0] data,
   output logic hit
);
   typedef struct packed {
      logic [4:0] idx;
      logic hit;
   } ckd_km_t;
   ckd_km_t st, next_st;
   always_comb begin
      next_st = st;
      next_st.hit = 1'b0;
      if (clear) begin
         next_st.idx = 5'h00;
      end else if (strobe) begin
         if (data == ckd_pkg::KEY_BYTES[st.idx]) begin
            next_st.idx = st.idx + 5'h01;
            next_st.hit = (st.idx == 5'(ckd_pkg::KEY_LEN - 1));
         end else if (data == ckd_pkg::KEY_BYTES[0]) begin // [R23]
            next_st.idx = 5'h01;
         end else begin
            next_st.idx = 5'h00; // [R23]
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign hit = st.hit;
endmodule

/* src/ckd_host.sv */
// host end: turns user byte requests into single-cycle bus writes
`timescale 1ns/1ps
module ckd_host (
   input wire logic clk,
   input wire logic rst_b,
   ckd_if.host bus,
   input wire logic req,
   input wire logic [15:0] req_addr,
   input wire logic [7:0] req_data,
   input wire logic req_reset,
   output logic busy
);
   typedef struct packed {
      logic wr;
      logic [15:0] addr;
      logic [7:0] data;
      logic rdrv;
   } ckd_host_t;
   ckd_host_t st, next_st;
   always_comb begin
      next_st = st;
      next_st.wr = 1'b0;
      next_st.rdrv = req_reset; // [R19]
      // back-to-back writes allowed; user keeps key and command order [R4] [R6] [R13]
      if (req && !req_reset) begin
         next_st.wr = 1'b1;
         next_st.addr = req_addr;
         next_st.data = req_data;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign bus.wr = st.wr;
   assign bus.addr = st.addr;
   assign bus.data = st.data;
   assign bus.bus_reset_drive = st.rdrv;
   assign busy = st.wr;
endmodule

/* verif/ckd_chk_sva.sv */
// checker: watches the host-to-device link and the device's mode flags
`timescale 1ns/1ps
module ckd_chk (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic wr,
   input wire logic [15:0] addr,
   input wire logic [7:0] data,
   input wire logic bus_reset_drive,
   input wire logic config_mode,
   input wire logic chip_active,
   input wire logic [7:0] card_select,
   input wire logic std_key_locked,
   input wire logic vnd_key_locked
);
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   chk_idle_after_rst: assert property ($rose(rst_b) |-> !config_mode && !chip_active)
      else $error("device not idle after reset");
   chk_cfg_from_key: assert property ($rose(config_mode) |->
      $past(wr, 2) && $past(addr, 2) == ckd_pkg::ADDR_PORT && $past(data, 2) == 8'h1a)
      else $error("config mode entered without last key byte");
   // assumes the csn byte is not itself a parameter of an earlier command
   chk_csn_store: assert property (config_mode && wr && addr == ckd_pkg::ADDR_PORT
      && data == ckd_pkg::CMD_CSN ##2 wr && addr == ckd_pkg::ADDR_PORT
      |=> card_select == $past(data))
      else $error("card select not stored");
   chk_chip_on: assert property (config_mode && wr && addr == ckd_pkg::ADDR_PORT
      && data == ckd_pkg::CMD_CHIP_ON |=> chip_active && !config_mode)
      else $error("chip activate not taken");
   chk_vnd_sticky: assert property (vnd_key_locked && !bus_reset_drive |=> vnd_key_locked)
      else $error("vendor key lock dropped");
   chk_std_sticky: assert property (std_key_locked && !bus_reset_drive |=> std_key_locked)
      else $error("standard key lock dropped");
   chk_bus_reset: assert property (bus_reset_drive |=>
      !vnd_key_locked && !std_key_locked && !config_mode && !chip_active)
      else $error("bus reset did not clear state");
   chk_key_locked: assert property (vnd_key_locked && !config_mode |=> !config_mode)
      else $error("locked key entered config mode");
endmodule

/* verif/tb.sv */
// testbench: host end driving the device end across the link
`timescale 1ns/1ps
module tb;
   logic clk = 0;
   logic rst_b = 0;
   logic req = 0;
   logic req_reset = 0;
   logic [15:0] req_addr = 16'h0000;
   logic [7:0] req_data = 8'h00;
   logic rom_valid = 1'h1;
   logic [1:0] rom_lock = 2'h0;
   logic [15:0] rom_sig = 16'h55bb;
   logic config_mode, chip_active, std_key_locked, vnd_key_locked, rom_present;
   logic [7:0] card_select;
   logic [5:0] ldev_active;
   logic [95:0] io_base0, io_base1, io_base2;
   logic [47:0] irq_sel0, irq_sel1, dma_sel0, dma_sel1;
   int error_cnt = 0;
   int num_checks = 0;
   logic [7:0] prog [$] = '{8'h06, 8'h01, 8'h15, 8'h00, 8'h47, 8'h05, 8'h34, 8'h48, 8'h03,
      8'h88, 8'h42, 8'h02, 8'h20, 8'h22, 8'h05, 8'h27, 8'h07, 8'h2a, 8'h01, 8'h25, 8'h03,
      8'h33, 8'h01, 8'h15, 8'h02, 8'h47, 8'h01, 8'h20, 8'h33, 8'h01, 8'h15, 8'h03, 8'h33,
      8'h01, 8'h33, 8'h00, 8'h99, 8'h15, 8'h07, 8'h22, 8'h0b};
   always #25 clk = ~clk;
   ckd_if bus_if ();
   ckd_host u_ckd_host (.clk(clk), .rst_b(rst_b), .bus(bus_if.host), .req(req),
      .req_addr(req_addr), .req_data(req_data), .req_reset(req_reset), .busy());
   ckd_device u_ckd_device (.clk(clk), .rst_b(rst_b), .bus(bus_if.dev), .rom_valid(rom_valid),
      .rom_sig0(rom_sig[15:8]), .rom_sig1(rom_sig[7:0]), .rom_lock_std(rom_lock[1]),
      .rom_lock_vnd(rom_lock[0]),
      .config_mode(config_mode), .chip_active(chip_active), .card_select(card_select),
      .ldev_active(ldev_active), .io_base0(io_base0), .io_base1(io_base1),
      .io_base2(io_base2), .irq_sel0(irq_sel0), .irq_sel1(irq_sel1), .dma_sel0(dma_sel0),
      .dma_sel1(dma_sel1), .std_key_locked(std_key_locked), .vnd_key_locked(vnd_key_locked),
      .rom_present(rom_present));
   ckd_chk u_ckd_chk (.clk(clk), .rst_b(rst_b), .wr(bus_if.wr), .addr(bus_if.addr),
      .data(bus_if.data), .bus_reset_drive(bus_if.bus_reset_drive), .config_mode(config_mode),
      .chip_active(chip_active), .card_select(card_select), .std_key_locked(std_key_locked),
      .vnd_key_locked(vnd_key_locked));
   // ---------------------------------------------
   // access and compare tasks
   // ---------------------------------------------
   // one write every two cycles keeps clear of the post-key gap
   task automatic wb(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 req = 1;
      req_addr = a;
      req_data = d;
      @(posedge clk);
      #1 req = 0;
   endtask
   task automatic cw(input logic [7:0] d);
      wb(ckd_pkg::ADDR_PORT, d);
   endtask
   task automatic key(input int from);
      for (int i = from; i < 32; i++) cw(ckd_pkg::KEY_BYTES[i]);
   endtask
   task automatic settle;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic cv(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rst(input logic [1:0] lock, input logic [15:0] sig);
      #1 rst_b = 0;
      rom_lock = lock;
      rom_sig = sig;
      repeat (2) @(posedge clk);
      #1 rst_b = 1;
      settle();
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial begin
      #500000;
      error_cnt++;
      conclude();
   end
   initial begin
      rst(2'h0, 16'h55bb);
      cv(config_mode, 16'h0);
      cv(rom_present, 16'h1);
      for (int i = 0; i < 6; i++) cw(ckd_pkg::KEY_BYTES[i % 5]);
      key(1);
      settle();
      cv(config_mode, 16'h1);
      $display("test key done");
      foreach (prog[i]) cw(prog[i]);
      settle();
      cv(ldev_active, 16'h0);
      cw(8'h79);
      settle();
      cv({config_mode, chip_active}, 16'h1);
      cv(card_select, 8'h01);
      cv(io_base0[15:0], 16'h0534);
      cv(io_base1[15:0], 16'h0388);
      cv(io_base2[15:0], 16'h0220);
      cv(io_base0[47:32], 16'h0120);
      cv(irq_sel1[7:0], 8'h07);
      cv({dma_sel0[7:0], dma_sel1[7:0]}, 16'h0103);
      cv(ldev_active, 16'h05);
      for (int n = 0; n < 6; n++) cv(irq_sel0[n*8 +: 8], (n == 0) ? 16'h5 : 16'h0);
      cw(8'h06);
      cw(8'h05);
      settle();
      cv(card_select, 16'h01);
      $display("test program done");
      wb(16'h0125, 8'h56);
      settle();
      cv({vnd_key_locked, std_key_locked}, 16'h2);
      wb(16'h0125, 8'h55);
      key(0);
      settle();
      cv(std_key_locked, 16'h1);
      cv(config_mode, 16'h0);
      @(posedge clk);
      #1 req_reset = 1'h1;
      @(posedge clk);
      #1 req_reset = 1'h0;
      settle();
      cv({vnd_key_locked, std_key_locked, chip_active}, 16'h0);
      key(0);
      settle();
      cv(config_mode, 16'h1);
      $display("test lock done");
      rst(2'h3, 16'h55bb);
      cv({vnd_key_locked, std_key_locked}, 16'h3);
      key(0);
      settle();
      cv(config_mode, 16'h0);
      rst(2'h3, 16'h5500);
      cv({rom_present, vnd_key_locked, std_key_locked}, 16'h0);
      rst(2'h3, 16'h00bb);
      cv({rom_present, vnd_key_locked, std_key_locked}, 16'h0);
      rom_valid = 1'h0;
      rst(2'h3, 16'h55bb);
      cv({rom_present, vnd_key_locked}, 16'h0);
      rom_valid = 1'h1;
      settle();
      cv({rom_present, vnd_key_locked, std_key_locked}, 16'h7);
      $display("test rom done");
      conclude();
   end
endmodule
